// ==== core/reset_seq_consts.svh ====
// constants for the system reset sequencer
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH
`define RLS_MIN_CYC 8'd120
`define RLS_MAX_CYC 8'd144
`define RLS_SPREAD 8'd24
`define PC_RESET_ADDR 7'h00
`define PAGE_RESET 5'h00
`define LATCH_RESET 1'b1
`define MACHINE_CYC 8'd1
`define PIN_SYNC_RESET 3'h0
`define PIN_LVL_RESET 1'b0
`define PIN_DRIVE_LVL 1'b0
`define DRIVE_RESET 1'b0
`define JITTER_RESET 5'h00
`define JITTER_STEP 5'h01
`define CNT_RESET 8'h00
`define CNT_STEP 8'h01
`define CORE_RST_RESET 1'b1
`define HIZ_RESET 1'b1
`define OD_RESET 1'b1
`define PU_OFF_RESET 1'b1
`endif

// ==== core/reset_seq_pkg.sv ====
// types for the system reset sequencer
package reset_seq_pkg;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN = 2'b10
  } seq_state_e;
  typedef struct packed {
    logic soft_reset_instr;
    logic watchdog;
    logic power_on;
    logic supply_drop;
  } rst_src_s;
  typedef struct packed {
    logic [4:0] page;
    logic [6:0] addr;
  } pc_load_s;
endpackage

// ==== core/system_reset_sequencer.sv ====
// system reset sequencer: sources, release timing, safe port state
//
// What this block does
// - any of pin, soft reset, watchdog, power-on, supply drop enters reset.
// - after release, program counter loads address 0 of page 0.
// - after pin goes high, count 120 to 143 oscillator cycles, then run.
// - soft reset instruction drives the reset pin low itself.
// - power-on detector resets the device, on variants that have it.
// - in reset, every port pin is high impedance.
// - in reset, every port output latch is set to 1.
// - in reset, every port driver is N-channel open drain.
// - in reset, every port pull-up is switched off.
// - defined reset values hold during reset; all but high-z also hold right after release.
`timescale 1ns/1ps
`include "reset_seq_consts.svh"
module system_reset_sequencer #(
  parameter int PORT_BITS = 14,
  parameter bit HAS_POWER_DET = 1'b1
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // reset pin, open drain
  input wire logic reset_pin_b_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  // internal reset sources
  input reset_seq_pkg::rst_src_s src_i,
  // core control
  output logic core_rst_o,
  output reset_seq_pkg::pc_load_s pc_load_o,
  output logic pc_load_en_o,
  // port safe state
  output logic [PORT_BITS-1:0] port_hiz_o,
  output logic [PORT_BITS-1:0] port_latch_o,
  output logic [PORT_BITS-1:0] port_od_o,
  output logic [PORT_BITS-1:0] port_pu_off_o
);
  import reset_seq_pkg::*;

  // reset pin: three flops, level taken only when the last two agree,
  // so a single-cycle glitch on the pin never reaches the sequencer
  logic [2:0] pin_sync_r;
  logic [2:0] pin_sync_nxt;
  logic pin_lvl_r;
  logic pin_lvl_nxt;

  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], reset_pin_b_i};
    pin_lvl_nxt = pin_lvl_r;
    if (pin_sync_r[2] == pin_sync_r[1]) begin
      pin_lvl_nxt = pin_sync_r[2];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pin_sync_r <= `PIN_SYNC_RESET;
      pin_lvl_r <= `PIN_LVL_RESET;
    end else if (clk_en_i) begin
      pin_sync_r <= pin_sync_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // soft reset pulls the pin and keeps pulling until the synchronised
  // level reads low; limitation: a pin clamped high would hang here
  logic drive_r;
  logic drive_nxt;
  logic pin_out_r;
  logic pin_out_nxt;

  always_comb begin
    drive_nxt = src_i.soft_reset_instr | (drive_r & pin_lvl_r);
    pin_out_nxt = `PIN_DRIVE_LVL;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      drive_r <= `DRIVE_RESET;
      pin_out_r <= `PIN_DRIVE_LVL;
    end else if (clk_en_i) begin
      drive_r <= drive_nxt;
      pin_out_r <= pin_out_nxt;
    end
  end

  // reset causes; detector inputs only count on variants that have them
  logic internal_src;
  logic any_src;

  always_comb begin
    internal_src = src_i.soft_reset_instr | src_i.watchdog;
    if (HAS_POWER_DET) begin
      internal_src = internal_src | src_i.power_on;
      internal_src = internal_src | src_i.supply_drop;
    end
    // the pin's own low and our own drive both hold the core in reset
    any_src = internal_src | drive_r | !pin_lvl_r;
  end

  // release sequencer
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] target_r;
  logic [7:0] target_nxt;
  logic [4:0] jitter_r;
  logic [4:0] jitter_nxt;
  logic [4:0] jitter_mod;
  logic core_rst_r;
  logic core_rst_nxt;
  logic pcl_r;
  logic pcl_nxt;
  pc_load_s pc_load_r;
  pc_load_s pc_load_nxt;

  // free-running jitter stands in for the internal state at reset; it
  // is folded below the spread so the count never leaves its span
  always_comb begin
    jitter_nxt = jitter_r + `JITTER_STEP;
    jitter_mod = jitter_r;
    if (jitter_r >= 5'(`RLS_SPREAD)) begin
      jitter_mod = jitter_r - 5'(`RLS_SPREAD);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      jitter_r <= `JITTER_RESET;
    end else if (clk_en_i) begin
      jitter_r <= jitter_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    target_nxt = target_r;
    pcl_nxt = 1'b0;
    unique case (state_r)
      ST_HOLD: begin
        cnt_nxt = `CNT_RESET;
        if (!any_src) begin
          state_nxt = ST_COUNT;
          target_nxt = `RLS_MIN_CYC + {3'h0, jitter_mod};
        end
      end
      ST_COUNT: begin
        cnt_nxt = cnt_r + `CNT_STEP;
        // cycles spent in this state equal the target
        if (cnt_nxt >= target_r) begin
          state_nxt = ST_RUN;
          pcl_nxt = 1'b1;
        end
      end
      ST_RUN: begin
        cnt_nxt = cnt_r;
      end
      // unused code: fall back to holding rather than running blind
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
    // any cause during count or run starts over from hold
    if (any_src) begin
      state_nxt = ST_HOLD;
      cnt_nxt = `CNT_RESET;
      pcl_nxt = 1'b0;
    end
    core_rst_nxt = (state_nxt != ST_RUN);
    pc_load_nxt = '{page: `PAGE_RESET, addr: `PC_RESET_ADDR};
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r <= ST_HOLD;
      cnt_r <= `CNT_RESET;
      target_r <= `RLS_MIN_CYC;
      core_rst_r <= `CORE_RST_RESET;
      pcl_r <= 1'b0;
      pc_load_r <= '{page: `PAGE_RESET, addr: `PC_RESET_ADDR};
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      target_r <= target_nxt;
      core_rst_r <= core_rst_nxt;
      pcl_r <= pcl_nxt;
      pc_load_r <= pc_load_nxt;
    end
  end

  // port safe state, one set of flops per bit; only high-z is released
  // here, the rest keep reset values until software moves them
  genvar g;
  generate
    for (g = 0; g < PORT_BITS; g++) begin : g_port
      logic hiz_r;
      logic hiz_nxt;
      logic latch_r;
      logic latch_nxt;
      logic od_r;
      logic od_nxt;
      logic puoff_r;
      logic puoff_nxt;

      // follow the next state so ports settle on the core's edge
      always_comb begin
        hiz_nxt = core_rst_nxt;
        latch_nxt = latch_r;
        od_nxt = od_r;
        puoff_nxt = puoff_r;
        if (core_rst_nxt) begin
          latch_nxt = `LATCH_RESET;
          od_nxt = `OD_RESET;
          puoff_nxt = `PU_OFF_RESET;
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          hiz_r <= `HIZ_RESET;
          latch_r <= `LATCH_RESET;
          od_r <= `OD_RESET;
          puoff_r <= `PU_OFF_RESET;
        end else if (clk_en_i) begin
          hiz_r <= hiz_nxt;
          latch_r <= latch_nxt;
          od_r <= od_nxt;
          puoff_r <= puoff_nxt;
        end
      end

      assign port_hiz_o[g] = hiz_r;
      assign port_latch_o[g] = latch_r;
      assign port_od_o[g] = od_r;
      assign port_pu_off_o[g] = puoff_r;
    end
  endgenerate

  assign reset_pin_o = pin_out_r;
  assign reset_pin_oe_o = drive_r;
  assign core_rst_o = core_rst_r;
  assign pc_load_en_o = pcl_r;
  assign pc_load_o = pc_load_r;
endmodule

// ==== verif/system_reset_sequencer_asserts.sv ====
// checker for the system reset sequencer
`timescale 1ns/1ps
module system_reset_sequencer_asserts #(parameter int PORT_BITS = 14) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // observed
  input wire logic reset_pin_b_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input reset_seq_pkg::rst_src_s src_i,
  input wire logic core_rst_o,
  input reset_seq_pkg::pc_load_s pc_load_o,
  input wire logic pc_load_en_o,
  input wire logic [PORT_BITS-1:0] port_hiz_o,
  input wire logic [PORT_BITS-1:0] port_latch_o,
  input wire logic [PORT_BITS-1:0] port_od_o,
  input wire logic [PORT_BITS-1:0] port_pu_off_o
);
  import reset_seq_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // quiet cycles since the last reset cause; wrap is harmless in run
  logic [7:0] cnt_r, cnt_nxt;
  // frozen cycles do not count towards the release time
  always_comb begin
    cnt_nxt = clk_en_i ? cnt_r + 8'h01 : cnt_r;
    if (!reset_pin_b_i || |src_i) begin
      cnt_nxt = 8'h00;
    end
  end
  always_ff @(posedge ref_clk_i) cnt_r <= rst_b_i ? cnt_nxt : 8'h00;
  property p_pin; !reset_pin_b_i |-> ##[1:5] core_rst_o; endproperty
  a_pin: assert property (p_pin) else $error("pin low missed");
  property p_src; |src_i |-> ##[1:2] core_rst_o; endproperty
  a_src: assert property (p_src) else $error("source missed");
  property p_pc;
    pc_load_en_o |-> pc_load_o == '0 && $past(core_rst_o);
  endproperty
  a_pc: assert property (p_pc) else $error("bad pc load");
  property p_one; pc_load_en_o |=> !pc_load_en_o; endproperty
  a_one: assert property (p_one) else $error("long pc pulse");
  property p_cnt; $fell(core_rst_o) |-> cnt_r inside {[120:152]}; endproperty
  a_cnt: assert property (p_cnt) else $error("release time");
  property p_soft; src_i.soft_reset_instr |=> reset_pin_oe_o; endproperty
  a_soft: assert property (p_soft) else $error("pin not driven");
  property p_pinlvl; reset_pin_oe_o |-> !reset_pin_o; endproperty
  a_pinlvl: assert property (p_pinlvl) else $error("pin not low");
  property p_hiz; core_rst_o |-> &port_hiz_o; endproperty
  a_hiz: assert property (p_hiz) else $error("port not hiz");
  property p_lat; core_rst_o |-> &port_latch_o; endproperty
  a_lat: assert property (p_lat) else $error("latch not set");
  property p_drv; core_rst_o |-> &(port_od_o & port_pu_off_o); endproperty
  a_drv: assert property (p_drv) else $error("driver mode");
endmodule
bind system_reset_sequencer system_reset_sequencer_asserts
  #(.PORT_BITS(PORT_BITS)) i_chk (.*);

// ==== verif/reset_supervisor.sv ====
// external supervisor on the open-drain reset pin
`timescale 1ns/1ps
module reset_supervisor (
  input wire logic ref_clk_i,
  input wire logic oe_i,
  input wire logic drv_i,
  output logic pin_b_o
);
  logic pull_r = 1'b0;
  // pull-up wins unless the device drives its data or we pull low
  assign pin_b_o = !pull_r && !(oe_i && !drv_i);
  task automatic hold_low(input int n);
    pull_r = 1'b1;
    repeat (n) @(negedge ref_clk_i);
    pull_r = 1'b0;
  endtask
endmodule

// ==== verif/system_reset_sequencer_tb_top.sv ====
// testbench for the system reset sequencer
`timescale 1ns/1ps
module system_reset_sequencer_tb_top;
  import reset_seq_pkg::*;
  logic ref_clk_i = 0, rst_b_i = 0, pin_b, oe, core_rst, pc_en, pin_d;
  logic en = 1'b1;
  rst_src_s src = '0;
  pc_load_s pc;
  logic [13:0] hiz, lat, od, pu;
  int err_total = 0, tests_run = 0, n;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  reset_supervisor i_sup (.ref_clk_i, .oe_i(oe), .drv_i(pin_d),
    .pin_b_o(pin_b));
  system_reset_sequencer i_dut (.ref_clk_i, .rst_b_i, .clk_en_i(en),
    .reset_pin_b_i(pin_b), .reset_pin_o(pin_d), .reset_pin_oe_o(oe),
    .src_i(src), .core_rst_o(core_rst), .pc_load_o(pc),
    .pc_load_en_o(pc_en), .port_hiz_o(hiz), .port_latch_o(lat),
    .port_od_o(od), .port_pu_off_o(pu));
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // waits out a release that began k cycles ago
  task automatic rel_chk(input int k);
    chk({core_rst, hiz, lat & od & pu}, {1'b1, {2{14'h3fff}}});
    n = k;
    while (core_rst === 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(n >= 120 && n <= 152, 1);
    chk({pc_en, pc, hiz}, {1'b1, 12'h000, 14'h0000});
  endtask
  task automatic t_pin;
    // the pin filter needs two agreeing samples, so hold three cycles
    i_sup.hold_low(3);
    repeat (4) @(negedge ref_clk_i);
    rel_chk(5);
  endtask
  task automatic t_src;
    for (int i = 0; i < 4; i++) begin
      src = rst_src_s'(4'h1 << i);
      @(negedge ref_clk_i);
      chk({oe, pin_b}, {i == 3, i != 3});
      src = '0;
      @(negedge ref_clk_i);
      rel_chk(0);
    end
  endtask
  task automatic t_restart;
    i_sup.hold_low(3);
    repeat (60) @(negedge ref_clk_i);
    i_sup.hold_low(3);
    repeat (4) @(negedge ref_clk_i);
    rel_chk(4);
  endtask
  // clock enable low must freeze the release count
  task automatic t_freeze;
    i_sup.hold_low(3);
    repeat (4) @(negedge ref_clk_i);
    en = 1'b0;
    repeat (200) @(negedge ref_clk_i);
    chk({core_rst, pc_en}, {1'b1, 1'b0});
    en = 1'b1;
    rel_chk(3);
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rel_chk(0);
    t_pin();
    t_src();
    t_restart();
    t_freeze();
    finish_test();
  end
  initial begin
    #100us;
    err_total++;
    finish_test();
  end
endmodule
